/* File: logic/salc_consts.vh */
`ifndef SALC_CONSTS_VH
`define SALC_CONSTS_VH
// Save-area geometry, in bytes from the area base.
`define SALC_LEGACY_SIZE    32'h0000_0200
`define SALC_HDR_OFFSET     32'h0000_0200
`define SALC_HDR_SIZE       32'h0000_0040
`define SALC_EXT_OFFSET     32'h0000_0240
`define SALC_ALIGN_MASK     32'h0000_003f
// Legacy-region byte boundaries (exclusive upper ends).
`define SALC_FP_A_END       9'h018
`define SALC_VEC_A_END      9'h020
`define SALC_FP_B_END       9'h0a0
`define SALC_VEC_B_END      9'h1a0
`define SALC_RSVD_END       9'h1d0
// Legacy byte classes.
`define SALC_CLS_UNUSED     3'h0
`define SALC_CLS_FP         3'h1
`define SALC_CLS_VEC        3'h2
`define SALC_CLS_RSVD       3'h4
// Bitmap fields.
`define SALC_COMPACT_BIT    6'h3f
`define SALC_FIRST_EXT      6'h02
`define SALC_LAST_EXT       6'h3e
// Register byte addresses.
`define SALC_A_CTRL         8'h00
`define SALC_A_STATUS       8'h04
`define SALC_A_BASE         8'h08
`define SALC_A_PRES_LO      8'h0c
`define SALC_A_PRES_HI      8'h10
`define SALC_A_COMP_LO      8'h14
`define SALC_A_COMP_HI      8'h18
`define SALC_A_UMASK_LO     8'h1c
`define SALC_A_UMASK_HI     8'h20
`define SALC_A_SMASK_LO     8'h24
`define SALC_A_SMASK_HI     8'h28
`define SALC_A_SUPP_LO      8'h2c
`define SALC_A_SUPP_HI      8'h30
`define SALC_A_ENUM_SEL     8'h40
`define SALC_A_ENUM_SIZE    8'h44
`define SALC_A_ENUM_OFF     8'h48
`define SALC_A_ENUM_ALIGN   8'h4c
`define SALC_A_RES_OFF      8'h50
`define SALC_A_RES_ADDR     8'h54
`define SALC_A_EXT_SIZE     8'h58
`define SALC_A_AREA_SIZE    8'h5c
`define SALC_A_LEG_QUERY    8'h60
`define SALC_A_LEG_CLASS    8'h64
// Field positions.
`define SALC_CTRL_START     0
`define SALC_ST_BUSY        0
`define SALC_ST_DONE        1
`define SALC_ST_COMPACT     2
`define SALC_ST_MISALIGN    3
`define SALC_ENUM_ALIGN_BIT 1
// Responses.
`define SALC_RESP_OKAY      2'h0
`define SALC_RESP_SLVERR    2'h2
`endif

/* File: logic/salc_layout.v */
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "salc_consts.vh"

// Notes on behaviour
// - First 512 bytes form the legacy region.
// - Components 0 and 1 live only there.
// - Fp stack bytes: 23:0 and 159:32.
// - Vector bytes: 31:24 and 415:160.
// - Bytes 511:464 unused; 463:416 reserved.
// - 64-byte header starts at offset 512.
// - Header bytes 7:0 hold presence bitmap.
// - Header bytes 15:8 hold compaction bitmap.
// - Compaction bit 63 selects compacted layout.
// - Bit 63 also selects compacted restore form.
// - Header bytes 63:16 reserved, no function.
// - Extended region starts at offset 576.
// - Size from supported and ORed masks, or from the compaction bitmap when compacted.
// - Only components 2 and up go extended.
// - Standard offsets come from enumeration table.
// - Compacted: cleared bit means no space.
// - First compacted component sits at 576.
// - Later offset: previous offset, size, align.
// - Align clear: previous offset plus size.
// - Align set: round end up to 64.
module salc_layout (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         layout_done_q,
	output reg         restore_compact_q
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_SCAN = 2'h1;
	localparam [1:0] ST_FIN  = 2'h2;

	reg  [31:0] base_q;
	reg  [63:0] pres_q;
	reg  [63:0] comp_q;
	reg  [63:0] umask_q;
	reg  [63:0] smask_q;
	reg  [63:0] supp_q;
	reg  [5:0]  enum_sel_q;
	reg  [31:0] enum_size [0:63];
	reg  [31:0] enum_off [0:63];
	reg  [63:0] enum_align_q;
	reg  [31:0] res_off [0:63];
	reg  [63:0] res_pres_q;
	reg  [31:0] ext_size_q;
	reg  [8:0]  leg_query_q;
	reg  [1:0]  state_q;
	reg  [5:0]  idx_q;
	reg  [31:0] end_q;
	reg         first_q;
	reg         compact_q;
	reg  [7:0]  aw_addr_q;
	reg         aw_held_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	reg         w_held_q;

	// Byte-lane merge used by the full-width writable registers.
	function [31:0] merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  st;
		integer k;
		begin
			merge = old;
			for (k = 0; k < 4; k = k + 1) begin
				if (st[k]) begin
					merge[k*8 +: 8] = wd[k*8 +: 8];
				end
			end
		end
	endfunction

	// Which state component owns a legacy-region byte.
	function [2:0] leg_class;
		input [8:0] b;
		begin
			if (b < `SALC_FP_A_END)
				leg_class = `SALC_CLS_FP;
			else if (b < `SALC_VEC_A_END)
				leg_class = `SALC_CLS_VEC;
			else if (b < `SALC_FP_B_END)
				leg_class = `SALC_CLS_FP;
			else if (b < `SALC_VEC_B_END)
				leg_class = `SALC_CLS_VEC;
			else if (b < `SALC_RSVD_END)
				leg_class = `SALC_CLS_RSVD;
			else
				leg_class = `SALC_CLS_UNUSED;
		end
	endfunction

	// Next multiple of 64 at or above a byte offset.
	function [31:0] ceil64;
		input [31:0] v;
		begin
			ceil64 = (v + `SALC_ALIGN_MASK) & ~`SALC_ALIGN_MASK;
		end
	endfunction

	// Only the enabled, supported components count in standard form.
	wire [63:0] feat_set = supp_q & (umask_q | smask_q);
	wire        incl     = compact_q ? comp_q[idx_q] : feat_set[idx_q];
	wire [31:0] cur_size = enum_size[idx_q];
	wire [31:0] cmp_loc  = first_q ? `SALC_EXT_OFFSET :
	                       (enum_align_q[idx_q] ? ceil64(end_q) : end_q);
	wire [31:0] std_loc  = enum_off[idx_q];
	wire [31:0] loc      = compact_q ? cmp_loc : std_loc;
	wire [31:0] loc_end  = loc + cur_size;

	wire        wr_go    = aw_held_q && w_held_q && !s_axi_bvalid;
	wire        start    = wr_go && (aw_addr_q == `SALC_A_CTRL) && w_strb_q[0] && w_data_q[`SALC_CTRL_START];

	// Write channel and register file.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SALC_RESP_OKAY;
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			aw_addr_q     <= 8'h00;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			base_q        <= 32'h0000_0000;
			pres_q        <= 64'h0000_0000_0000_0000;
			comp_q        <= 64'h0000_0000_0000_0000;
			umask_q       <= 64'h0000_0000_0000_0000;
			smask_q       <= 64'h0000_0000_0000_0000;
			supp_q        <= 64'h0000_0000_0000_0000;
			enum_sel_q    <= 6'h00;
			enum_align_q  <= 64'h0000_0000_0000_0000;
			leg_query_q   <= 9'h000;
		end else begin
			s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_go) begin
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `SALC_RESP_OKAY;
				case (aw_addr_q)
					`SALC_A_CTRL: begin
					end
					`SALC_A_BASE:      base_q              <= merge(base_q, w_data_q, w_strb_q);
					`SALC_A_PRES_LO:   pres_q[31:0]        <= merge(pres_q[31:0], w_data_q, w_strb_q);
					`SALC_A_PRES_HI:   pres_q[63:32]       <= merge(pres_q[63:32], w_data_q, w_strb_q);
					`SALC_A_COMP_LO:   comp_q[31:0]        <= merge(comp_q[31:0], w_data_q, w_strb_q);
					`SALC_A_COMP_HI:   comp_q[63:32]       <= merge(comp_q[63:32], w_data_q, w_strb_q);
					`SALC_A_UMASK_LO:  umask_q[31:0]       <= merge(umask_q[31:0], w_data_q, w_strb_q);
					`SALC_A_UMASK_HI:  umask_q[63:32]      <= merge(umask_q[63:32], w_data_q, w_strb_q);
					`SALC_A_SMASK_LO:  smask_q[31:0]       <= merge(smask_q[31:0], w_data_q, w_strb_q);
					`SALC_A_SMASK_HI:  smask_q[63:32]      <= merge(smask_q[63:32], w_data_q, w_strb_q);
					`SALC_A_SUPP_LO:   supp_q[31:0]        <= merge(supp_q[31:0], w_data_q, w_strb_q);
					`SALC_A_SUPP_HI:   supp_q[63:32]       <= merge(supp_q[63:32], w_data_q, w_strb_q);
					`SALC_A_ENUM_SEL: begin
						if (w_strb_q[0]) begin
							enum_sel_q <= w_data_q[5:0];
						end
					end
					`SALC_A_ENUM_SIZE: begin
					end
					`SALC_A_ENUM_OFF: begin
					end
					`SALC_A_ENUM_ALIGN: begin
						if (w_strb_q[0]) begin
							enum_align_q[enum_sel_q] <= w_data_q[`SALC_ENUM_ALIGN_BIT];
						end
					end
					`SALC_A_LEG_QUERY: begin
						if (w_strb_q[0]) begin
							leg_query_q[7:0] <= w_data_q[7:0];
						end
						if (w_strb_q[1]) begin
							leg_query_q[8] <= w_data_q[8];
						end
					end
					`SALC_A_STATUS, `SALC_A_RES_OFF, `SALC_A_RES_ADDR, `SALC_A_EXT_SIZE,
					`SALC_A_AREA_SIZE, `SALC_A_LEG_CLASS: begin
					end
					default: s_axi_bresp <= `SALC_RESP_SLVERR;
				endcase
			end
		end
	end

	// The enumeration sizes and offsets are plain memory without reset.
	always @(posedge aclk) begin
		if (wr_go && aw_addr_q == `SALC_A_ENUM_SIZE) begin
			enum_size[enum_sel_q] <= merge(enum_size[enum_sel_q], w_data_q, w_strb_q);
		end
		if (wr_go && aw_addr_q == `SALC_A_ENUM_OFF) begin
			enum_off[enum_sel_q] <= merge(enum_off[enum_sel_q], w_data_q, w_strb_q);
		end
	end

	// Offset scan. A start while busy is dropped, so a running scan never sees
	// its inputs swap format halfway through.
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q           <= ST_IDLE;
			idx_q             <= `SALC_FIRST_EXT;
			end_q             <= `SALC_EXT_OFFSET;
			first_q           <= 1'b1;
			compact_q         <= 1'b0;
			res_pres_q        <= 64'h0000_0000_0000_0000;
			ext_size_q        <= 32'h0000_0000;
			layout_done_q     <= 1'b0;
			restore_compact_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q           <= ST_SCAN;
						idx_q             <= `SALC_FIRST_EXT;
						end_q             <= `SALC_EXT_OFFSET;
						first_q           <= 1'b1;
						compact_q         <= comp_q[`SALC_COMPACT_BIT];
						restore_compact_q <= comp_q[`SALC_COMPACT_BIT];
						layout_done_q     <= 1'b0;
						res_pres_q        <= 64'h0000_0000_0000_0003;
					end
				end
				ST_SCAN: begin
					res_pres_q[idx_q] <= incl;
					if (incl) begin
						first_q <= 1'b0;
						if (compact_q)
							end_q <= loc_end;
						else if (loc_end > end_q)
							end_q <= loc_end;
					end
					if (idx_q == `SALC_LAST_EXT)
						state_q <= ST_FIN;
					else
						idx_q <= idx_q + 6'h01;
				end
				ST_FIN: begin
					ext_size_q    <= end_q - `SALC_EXT_OFFSET;
					layout_done_q <= 1'b1;
					state_q       <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Result offsets; absent components keep a stale value and read as zero.
	always @(posedge aclk) begin
		if (state_q == ST_SCAN && incl) begin
			res_off[idx_q] <= loc;
		end
	end

	// Read channel. Header bytes 63:16 have no register: they feed nothing.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SALC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `SALC_RESP_OKAY;
				s_axi_rdata  <= 32'h0000_0000;
				case (s_axi_araddr)
					`SALC_A_CTRL: begin
					end
					`SALC_A_STATUS: begin
						s_axi_rdata[`SALC_ST_BUSY]     <= (state_q != ST_IDLE);
						s_axi_rdata[`SALC_ST_DONE]     <= layout_done_q;
						s_axi_rdata[`SALC_ST_COMPACT]  <= restore_compact_q;
						s_axi_rdata[`SALC_ST_MISALIGN] <= |(base_q & `SALC_ALIGN_MASK);
					end
					`SALC_A_BASE:       s_axi_rdata <= base_q;
					`SALC_A_PRES_LO:    s_axi_rdata <= pres_q[31:0];
					`SALC_A_PRES_HI:    s_axi_rdata <= pres_q[63:32];
					`SALC_A_COMP_LO:    s_axi_rdata <= comp_q[31:0];
					`SALC_A_COMP_HI:    s_axi_rdata <= comp_q[63:32];
					`SALC_A_UMASK_LO:   s_axi_rdata <= umask_q[31:0];
					`SALC_A_UMASK_HI:   s_axi_rdata <= umask_q[63:32];
					`SALC_A_SMASK_LO:   s_axi_rdata <= smask_q[31:0];
					`SALC_A_SMASK_HI:   s_axi_rdata <= smask_q[63:32];
					`SALC_A_SUPP_LO:    s_axi_rdata <= supp_q[31:0];
					`SALC_A_SUPP_HI:    s_axi_rdata <= supp_q[63:32];
					`SALC_A_ENUM_SEL:   s_axi_rdata[5:0] <= enum_sel_q;
					`SALC_A_ENUM_SIZE:  s_axi_rdata <= enum_size[enum_sel_q];
					`SALC_A_ENUM_OFF:   s_axi_rdata <= enum_off[enum_sel_q];
					`SALC_A_ENUM_ALIGN: s_axi_rdata[`SALC_ENUM_ALIGN_BIT] <= enum_align_q[enum_sel_q];
					`SALC_A_RES_OFF: begin
						if (enum_sel_q < `SALC_FIRST_EXT)
							s_axi_rdata <= 32'h0000_0000;
						else if (res_pres_q[enum_sel_q])
							s_axi_rdata <= res_off[enum_sel_q];
					end
					`SALC_A_RES_ADDR: begin
						if (enum_sel_q < `SALC_FIRST_EXT)
							s_axi_rdata <= base_q;
						else if (res_pres_q[enum_sel_q])
							s_axi_rdata <= base_q + res_off[enum_sel_q];
					end
					`SALC_A_EXT_SIZE:   s_axi_rdata <= ext_size_q;
					`SALC_A_AREA_SIZE:  s_axi_rdata <= `SALC_LEGACY_SIZE + `SALC_HDR_SIZE + ext_size_q;
					`SALC_A_LEG_QUERY:  s_axi_rdata[8:0] <= leg_query_q;
					`SALC_A_LEG_CLASS:  s_axi_rdata[2:0] <= leg_class(leg_query_q);
					default:            s_axi_rresp <= `SALC_RESP_SLVERR;
				endcase
			end
		end
	end

endmodule // salc_layout

/* File: sim/salc_layout_checker.sv */
`timescale 1ns/1ps
`include "salc_consts.vh"
module salc_layout_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire [7:0]  s_axi_awaddr,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        layout_done_q,
	input wire        restore_compact_q
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	reg [7:0]  aw_q;
	reg [31:0] wd_q;
	reg        bv_q;
	reg        c63_q;
	reg [6:0]  cnt_q;
	// A start written while a scan runs is ignored, so it must not restart the count.
	wire exec_w = s_axi_bvalid && !bv_q;
	wire start_w = exec_w && aw_q == `SALC_A_CTRL && wd_q[0] && cnt_q == 7'h00;
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 8'h00;
			wd_q <= 32'h0;
			bv_q <= 1'b0;
			c63_q <= 1'b0;
			cnt_q <= 7'h00;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				aw_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				wd_q <= s_axi_wdata;
			bv_q <= s_axi_bvalid;
			if (exec_w && aw_q == `SALC_A_COMP_HI)
				c63_q <= wd_q[31];
			if (start_w)
				cnt_q <= 7'h3e;
			else if (cnt_q != 7'h00)
				cnt_q <= cnt_q - 7'h01;
		end
	end
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
	w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready held");
	read_answer_a: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	scan_low_a: assert property (start_w |-> !layout_done_q [*8]) else $error("done during scan");
	scan_len_a: assert property (start_w |-> ##61 !layout_done_q ##1 layout_done_q)
		else $error("scan length wrong");
	restore_form_a: assert property (start_w |-> restore_compact_q == c63_q)
		else $error("restore form wrong");
	form_stable_a: assert property (!start_w |-> $stable(restore_compact_q))
		else $error("restore form moved");
	unmapped_resp_a: assert property (s_axi_bvalid && aw_q >= 8'h68 |-> s_axi_bresp == `SALC_RESP_SLVERR)
		else $error("unmapped write accepted");
	cover property (start_w);
	cover property (start_w && c63_q);
	cover property (s_axi_bvalid && s_axi_bresp == `SALC_RESP_SLVERR);
endmodule // salc_layout_checker
bind salc_layout salc_layout_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .layout_done_q, .restore_compact_q);

/* File: sim/salc_seq_model.sv */
`timescale 1ns/1ps
// Register side of the save and restore sequencer; one write and one read at most at a time.
module salc_seq_model (
	input  wire         aclk,
	output logic [7:0]  s_axi_awaddr = 8'h00,
	output logic [2:0]  s_axi_awprot = 3'h0,
	output logic        s_axi_awvalid = 1'b0,
	input  wire         s_axi_awready,
	output logic [31:0] s_axi_wdata = 32'h0,
	output logic [3:0]  s_axi_wstrb = 4'hf,
	output logic        s_axi_wvalid = 1'b0,
	input  wire         s_axi_wready,
	input  wire  [1:0]  s_axi_bresp,
	input  wire         s_axi_bvalid,
	output logic        s_axi_bready = 1'b0,
	output logic [7:0]  s_axi_araddr = 8'h00,
	output logic [2:0]  s_axi_arprot = 3'h0,
	output logic        s_axi_arvalid = 1'b0,
	input  wire         s_axi_arready,
	input  wire  [31:0] s_axi_rdata,
	input  wire  [1:0]  s_axi_rresp,
	input  wire         s_axi_rvalid,
	output logic        s_axi_rready = 1'b0
);
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // salc_seq_model

/* File: sim/test_salc_layout.sv */
`timescale 1ns/1ps
`include "salc_consts.vh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module test_salc_layout;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	wire [7:0]   s_axi_awaddr, s_axi_araddr;
	wire [2:0]   s_axi_awprot, s_axi_arprot;
	wire [31:0]  s_axi_wdata, s_axi_rdata;
	wire [3:0]   s_axi_wstrb;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	wire         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, layout_done_q, restore_compact_q;
	int          errors = 0;
	int          checks = 0;
	logic [1:0]  rsp;
	logic [31:0] rv, base, ex, mx;
	logic [9:0]  um, sm, sp, bm;
	int          sz [2:9];
	int          al [2:9];
	int          lb [12] = '{0, 23, 24, 31, 32, 159, 160, 415, 416, 463, 464, 511};
	salc_layout u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .layout_done_q, .restore_compact_q);
	salc_seq_model u_seq (.aclk, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	always #12.5 aclk = ~aclk;
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		u_seq.wr(a, d, rsp);
	endtask
	task automatic r(input logic [7:0] a);
		u_seq.rd(a, rv, rsp);
	endtask
	function automatic logic [2:0] lcls(input int b);
		if (b < 24 || (b >= 32 && b < 160))
			return `SALC_CLS_FP;
		if (b < 416)
			return `SALC_CLS_VEC;
		return (b < 464) ? `SALC_CLS_RSVD : `SALC_CLS_UNUSED;
	endfunction
	// The extended region opens on a 64-byte boundary, so the first packed piece needs no special case.
	function automatic logic [31:0] cpos(input int i, input logic [9:0] m);
		logic [31:0] e, loc;
		e = 32'h240;
		loc = 32'h0;
		for (int k = 2; k <= i; k++) begin
			if (m[k]) begin
				loc = al[k] ? ((e + 32'h3f) & ~32'h3f) : e;
				e = loc + sz[k];
			end
		end
		return m[i] ? loc : 32'h0;
	endfunction
	function automatic logic [31:0] spos(input int i);
		return (sp[i] & (um[i] | sm[i])) ? 32'h240 + 32'h400 * (i - 2) : 32'h0;
	endfunction
	task automatic run(input logic c);
		w(`SALC_A_COMP_LO, {22'h0, bm});
		w(`SALC_A_COMP_HI, {c, 31'h0});
		w(`SALC_A_CTRL, 32'h1);
		for (int n = 0; n < 200 && !layout_done_q; n++)
			@(posedge aclk);
		`CHK("done", 1'b1, layout_done_q)
		`CHK("restore form", c, restore_compact_q)
		r(`SALC_A_COMP_HI);
		`CHK("compaction high", ({c, 31'h0}), rv)
		r(`SALC_A_STATUS);
		`CHK("status", ({28'h0, 1'h0, c, 2'h2}), rv)
		for (int i = 0; i < 10; i++) begin
			ex = (i < 2) ? 32'h0 : c ? cpos(i, bm) : spos(i);
			w(`SALC_A_ENUM_SEL, i);
			r(`SALC_A_RES_OFF);
			`CHK("offset", ex, rv)
			r(`SALC_A_RES_ADDR);
			`CHK("address", (i < 2) ? base : (ex != 0) ? base + ex : 32'h0, rv)
		end
		mx = 32'h240;
		for (int i = 2; i < 10; i++) begin
			ex = c ? cpos(i, bm) : spos(i);
			if (ex != 0 && ex + sz[i] > mx)
				mx = ex + sz[i];
		end
		r(`SALC_A_EXT_SIZE);
		`CHK("extended size", mx - 32'h240, rv)
		r(`SALC_A_AREA_SIZE);
		`CHK("area size", mx, rv)
	endtask
	initial begin
		rv = $urandom(32'h7f25);
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 2; i < 10; i++) begin
			sz[i] = $urandom_range(1, 1023);
			al[i] = $urandom_range(0, 1);
			w(`SALC_A_ENUM_SEL, i);
			w(`SALC_A_ENUM_SIZE, sz[i]);
			w(`SALC_A_ENUM_OFF, 32'h240 + 32'h400 * (i - 2));
			w(`SALC_A_ENUM_ALIGN, al[i] << 1);
		end
		base = $urandom & ~32'h3f;
		w(`SALC_A_BASE, base);
		mx = $urandom;
		w(`SALC_A_PRES_LO, mx);
		r(`SALC_A_PRES_LO);
		`CHK("presence bitmap", mx, rv)
		for (int i = 0; i < 16; i++) begin
			ex = (i < 12) ? lb[i] : $urandom_range(0, 511);
			w(`SALC_A_LEG_QUERY, ex);
			r(`SALC_A_LEG_CLASS);
			`CHK("legacy class", ({29'h0, lcls(ex)}), rv)
		end
		um = 10'($urandom);
		sm = 10'($urandom);
		sp = 10'($urandom);
		bm = 10'($urandom);
		w(`SALC_A_UMASK_LO, {22'h0, um});
		w(`SALC_A_SMASK_LO, {22'h0, sm});
		w(`SALC_A_SUPP_LO, {22'h0, sp});
		run(1'b0);
		bm = 10'h3ff;
		run(1'b1);
		repeat (3) begin
			bm = 10'($urandom);
			run(1'b1);
		end
		w(`SALC_A_BASE, base | 32'h20);
		r(`SALC_A_STATUS);
		`CHK("misaligned flag", 1'b1, rv[`SALC_ST_MISALIGN])
		u_seq.wr(8'h80, 32'h1, rsp);
		`CHK("write resp", `SALC_RESP_SLVERR, rsp)
		u_seq.rd(8'h80, rv, rsp);
		`CHK("read resp", `SALC_RESP_SLVERR, rsp)
		`CHK("read data", 32'h0, rv)
		conclude();
	end
	initial begin
		#500000;
		errors++;
		conclude();
	end
	task automatic conclude();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
endmodule // test_salc_layout
